/* File: logic/roa_pkg.sv */
// package: constants and carrier types for the remote output assignment block
package roa_pkg;

  // ==========================================================================
  // sizes
  localparam int NUM_SIG = 4;
  localparam int NUM_OUT = 6;
  localparam int ASSIGN_W = 3;

  // ==========================================================================
  // assignment values
  localparam logic [ASSIGN_W-1:0] ASSIGN_NONE = 3'h0;
  localparam logic [ASSIGN_W-1:0] ASSIGN_MAX = 3'h6;
  localparam logic [ASSIGN_W-1:0] ASSIGN_DEFAULT = 3'h0;
  localparam logic [31:0] ASSIGN_MAX_WORD = 32'h0000_0006;

  // ==========================================================================
  // register offsets (byte addresses, one word each)
  localparam logic [7:0] ADDR_STAGE_BASE = 8'h00;
  localparam logic [7:0] ADDR_EFF_BASE = 8'h10;
  localparam logic [7:0] ADDR_GP_OUT = 8'h20;
  localparam logic [7:0] ADDR_SINGLE = 8'h24;
  localparam logic [7:0] ADDR_CTRL = 8'h28;
  localparam logic [7:0] ADDR_OUT_LEVEL = 8'h2c;

  // ==========================================================================
  // fields and reset values
  localparam int CTRL_SAVE_BIT = 0;
  localparam int SINGLE_IDX_LSB = 0;
  localparam int SINGLE_VAL_BIT = 4;
  localparam logic [NUM_OUT-1:0] GP_RESET = 6'h00;
  localparam logic [31:0] RDATA_IDLE = 32'h0000_0000;

  // ==========================================================================
  // carrier types
  typedef logic [ASSIGN_W-1:0] roa_assign_type;
  typedef roa_assign_type [NUM_SIG-1:0] roa_assign_vec_type;

  typedef struct packed {
    logic seq_running;
    logic pause_state;
    logic brake_release;
    logic position_ready;
  } roa_status_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } roa_bus_req_type;

  typedef struct packed {
    logic [NUM_SIG-1:0] saved;
    roa_assign_vec_type value;
  } roa_nv_load_type;

  typedef struct packed {
    logic save;
    roa_assign_vec_type value;
  } roa_nv_save_type;

endpackage

/* File: logic/roa_assign_slot.sv */
// one assignment setting: staged value and value in effect
`timescale 1ns/100ps
`default_nettype none

module roa_assign_slot (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // power-up load
  input wire logic load,
  input wire logic load_saved,
  input wire roa_pkg::roa_assign_type load_value,
  // register write
  input wire logic wr,
  input wire logic [31:0] wdata,
  // values
  output roa_pkg::roa_assign_type staged,
  output roa_pkg::roa_assign_type effective
);

  typedef struct packed {
    roa_pkg::roa_assign_type staged;
    roa_pkg::roa_assign_type effective;
  } roa_slot_state_type;

  roa_slot_state_type st_q;
  roa_slot_state_type st_d;
  roa_pkg::roa_assign_type boot_value;

  // ==========================================================================
  // next state
  always_comb begin
    st_d = st_q;
    boot_value = load_saved ? load_value : roa_pkg::ASSIGN_DEFAULT;
    if (load) begin
      // unsaved staging is dropped, both copies come from the store, or the default if nothing was saved
      st_d.staged = boot_value;
      st_d.effective = boot_value;
    end else if (wr && wdata <= roa_pkg::ASSIGN_MAX_WORD) begin
      st_d.staged = wdata[roa_pkg::ASSIGN_W-1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st_q <= '{staged: roa_pkg::ASSIGN_DEFAULT, effective: roa_pkg::ASSIGN_DEFAULT};
    end else begin
      st_q <= st_d;
    end
  end

  assign staged = st_q.staged;
  assign effective = st_q.effective;

  // ==========================================================================
  // checks
  property p_reject_range;
    @(posedge clk_sys) disable iff (!nrst)
    (wr && !load && wdata > roa_pkg::ASSIGN_MAX_WORD) |=> (staged == $past(staged));
  endproperty
  a_reject_range: assert property (p_reject_range) else $error("out of range value was staged");

  property p_accept_range;
    @(posedge clk_sys) disable iff (!nrst)
    (wr && !load && wdata <= roa_pkg::ASSIGN_MAX_WORD) |=> (staged == $past(wdata[2:0]));
  endproperty
  a_accept_range: assert property (p_accept_range) else $error("legal value was not staged");

  property p_stage_not_live;
    @(posedge clk_sys) disable iff (!nrst)
    (wr && !load) |=> (effective == $past(effective));
  endproperty
  a_stage_not_live: assert property (p_stage_not_live) else $error("write changed value in effect");

endmodule // roa_assign_slot

`default_nettype wire

/* File: logic/roa_remote_out.sv */
// top: routes four status signals onto six remote outputs
`timescale 1ns/100ps
`default_nettype none

module roa_remote_out (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // register port
  input wire roa_pkg::roa_bus_req_type bus,
  output logic [31:0] rdata,
  // status signals from the controller
  input wire roa_pkg::roa_status_type status,
  // nonvolatile store
  input wire roa_pkg::roa_nv_load_type nv_load,
  output roa_pkg::roa_nv_save_type nv_save,
  // remote outputs
  output logic [roa_pkg::NUM_OUT-1:0] remote_out
);

  typedef struct packed {
    logic loaded;
    logic [roa_pkg::NUM_OUT-1:0] gp;
    logic [roa_pkg::NUM_OUT-1:0] out;
    logic [31:0] rdata;
    roa_pkg::roa_nv_save_type save;
  } roa_top_state_type;

  roa_top_state_type st_q;
  roa_top_state_type st_d;
  roa_pkg::roa_assign_vec_type staged;
  roa_pkg::roa_assign_vec_type eff;
  logic [roa_pkg::NUM_SIG-1:0] stage_wr;
  logic [roa_pkg::NUM_SIG-1:0] sig_vec;
  logic [roa_pkg::NUM_OUT-1:0] assigned_mask;
  logic [roa_pkg::NUM_OUT-1:0] route_lvl;
  logic load;

  assign load = !st_q.loaded;
  assign sig_vec = status;

  // ==========================================================================
  // assignment settings, one per routable signal
  for (genvar s = 0; s < roa_pkg::NUM_SIG; s++) begin : g_slot
    assign stage_wr[s] = bus.wr && bus.addr == roa_pkg::ADDR_STAGE_BASE + 8'(4 * s);
    roa_assign_slot u_slot (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .load(load),
      .load_saved(nv_load.saved[s]),
      .load_value(nv_load.value[s]),
      .wr(stage_wr[s]),
      .wdata(bus.wdata),
      .staged(staged[s]),
      .effective(eff[s])
    );
  end

  // ==========================================================================
  // routing map from the values in effect
  always_comb begin
    assigned_mask = '0;
    route_lvl = '0;
    for (int s = 0; s < roa_pkg::NUM_SIG; s++) begin
      // value 0 routes nowhere; several signals on one output are or-ed
      if (eff[s] != roa_pkg::ASSIGN_NONE && eff[s] <= roa_pkg::ASSIGN_MAX) begin
        assigned_mask[eff[s] - 3'h1] = 1'b1;
        route_lvl[eff[s] - 3'h1] = route_lvl[eff[s] - 3'h1] | sig_vec[s];
      end
    end
  end

  // ==========================================================================
  // next state: general outputs, read port, save request
  always_comb begin
    st_d = st_q;
    st_d.loaded = 1'b1;
    st_d.save.save = 1'b0;
    st_d.rdata = roa_pkg::RDATA_IDLE;
    if (bus.wr && bus.addr == roa_pkg::ADDR_GP_OUT) begin
      // masked bits keep their old level; a signal is only unassigned at a reset, which clears that level
      st_d.gp = (st_q.gp & assigned_mask) | (bus.wdata[roa_pkg::NUM_OUT-1:0] & ~assigned_mask);
    end
    if (bus.wr && bus.addr == roa_pkg::ADDR_SINGLE) begin
      for (int k = 0; k < roa_pkg::NUM_OUT; k++) begin
        // output numbers start at 1, anything else is ignored
        if (bus.wdata[roa_pkg::SINGLE_IDX_LSB +: 3] == 3'(k + 1) && !assigned_mask[k]) begin
          st_d.gp[k] = bus.wdata[roa_pkg::SINGLE_VAL_BIT];
        end
      end
    end
    if (bus.wr && bus.addr == roa_pkg::ADDR_CTRL && bus.wdata[roa_pkg::CTRL_SAVE_BIT]) begin
      st_d.save.save = 1'b1;
      st_d.save.value = staged;
    end
    st_d.out = (st_d.gp & ~assigned_mask) | (route_lvl & assigned_mask);
    if (bus.rd) begin
      unique case (bus.addr)
        roa_pkg::ADDR_STAGE_BASE: st_d.rdata = 32'(staged[0]);
        roa_pkg::ADDR_STAGE_BASE + 8'h04: st_d.rdata = 32'(staged[1]);
        roa_pkg::ADDR_STAGE_BASE + 8'h08: st_d.rdata = 32'(staged[2]);
        roa_pkg::ADDR_STAGE_BASE + 8'h0c: st_d.rdata = 32'(staged[3]);
        roa_pkg::ADDR_EFF_BASE: st_d.rdata = 32'(eff[0]);
        roa_pkg::ADDR_EFF_BASE + 8'h04: st_d.rdata = 32'(eff[1]);
        roa_pkg::ADDR_EFF_BASE + 8'h08: st_d.rdata = 32'(eff[2]);
        roa_pkg::ADDR_EFF_BASE + 8'h0c: st_d.rdata = 32'(eff[3]);
        roa_pkg::ADDR_GP_OUT: st_d.rdata = 32'(st_q.gp);
        roa_pkg::ADDR_OUT_LEVEL: st_d.rdata = 32'(st_q.out);
        default: st_d.rdata = roa_pkg::RDATA_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st_q.loaded <= 1'b0;
      st_q.gp <= roa_pkg::GP_RESET;
      st_q.out <= roa_pkg::GP_RESET;
      st_q.rdata <= roa_pkg::RDATA_IDLE;
      st_q.save <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata = st_q.rdata;
  assign nv_save = st_q.save;
  assign remote_out = st_q.out;

  // ==========================================================================
  // checks
  property p_gp_start;
    @(posedge clk_sys) disable iff (!nrst)
    $rose(nrst) |-> (st_q.gp == 6'h00 && remote_out == 6'h00);
  endproperty
  a_gp_start: assert property (p_gp_start) else $error("outputs active after startup");

  property p_gp_ignore;
    @(posedge clk_sys) disable iff (!nrst)
    (bus.wr && (bus.addr == roa_pkg::ADDR_GP_OUT || bus.addr == roa_pkg::ADDR_SINGLE))
      |=> (((st_q.gp ^ $past(st_q.gp)) & $past(assigned_mask)) == 6'h00);
  endproperty
  a_gp_ignore: assert property (p_gp_ignore) else $error("write reached an assigned output");

  property p_load_saved;
    @(posedge clk_sys) disable iff (!nrst)
    (load && nv_load.saved[0]) |=> (eff[0] == $past(nv_load.value[0]) && staged[0] == eff[0]);
  endproperty
  a_load_saved: assert property (p_load_saved) else $error("saved value not restored");

  property p_load_default;
    @(posedge clk_sys) disable iff (!nrst)
    (load && !nv_load.saved[3]) |=> (eff[3] == 3'h0);
  endproperty
  a_load_default: assert property (p_load_default) else $error("unsaved setting not cleared");

  property p_eff_frozen;
    @(posedge clk_sys) disable iff (!nrst)
    st_q.loaded |=> $stable(eff);
  endproperty
  a_eff_frozen: assert property (p_eff_frozen) else $error("value in effect changed without reset");

  property p_save_pulse;
    @(posedge clk_sys) disable iff (!nrst)
    (bus.wr && bus.addr == roa_pkg::ADDR_CTRL && bus.wdata[0])
      |=> (nv_save.save && nv_save.value == $past(staged)) ##1 !nv_save.save;
  endproperty
  a_save_pulse: assert property (p_save_pulse) else $error("save request not issued");

  property p_route_brake;
    @(posedge clk_sys) disable iff (!nrst)
    (eff[1] == 3'h2 && status.brake_release) |=> remote_out[1];
  endproperty
  a_route_brake: assert property (p_route_brake) else $error("brake release not routed");

  property p_unassigned_gp;
    @(posedge clk_sys) disable iff (!nrst)
    (bus.wr && bus.addr == roa_pkg::ADDR_SINGLE && bus.wdata[2:0] == 3'h6 && !assigned_mask[5])
      |=> (remote_out[5] == $past(bus.wdata[roa_pkg::SINGLE_VAL_BIT]));
  endproperty
  a_unassigned_gp: assert property (p_unassigned_gp) else $error("free output does not follow its write");

  property p_zero_unrouted;
    @(posedge clk_sys) disable iff (!nrst)
    (eff == '0) |-> (assigned_mask == 6'h00);
  endproperty
  a_zero_unrouted: assert property (p_zero_unrouted) else $error("zero setting routed a signal");

  // no disable here: the reset values themselves are what is checked
  property p_reset_quiet;
    @(posedge clk_sys)
    !nrst |=> (remote_out == roa_pkg::GP_RESET && rdata == roa_pkg::RDATA_IDLE && !nv_save.save);
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not quiet after reset");

  property p_route_position;
    @(posedge clk_sys) disable iff (!nrst)
    (eff[0] == 3'h1 && status.position_ready) |=> remote_out[0];
  endproperty
  a_route_position: assert property (p_route_position) else $error("position ready not routed");

  // the store is read once per reset, later store changes must not leak in
  property p_load_once;
    @(posedge clk_sys) disable iff (!nrst)
    load |=> !load;
  endproperty
  a_load_once: assert property (p_load_once) else $error("settings loaded more than once");

  property p_save_quiet;
    @(posedge clk_sys) disable iff (!nrst)
    !(bus.wr && bus.addr == roa_pkg::ADDR_CTRL && bus.wdata[roa_pkg::CTRL_SAVE_BIT]) |=> !nv_save.save;
  endproperty
  a_save_quiet: assert property (p_save_quiet) else $error("save request without command");

endmodule // roa_remote_out

`default_nettype wire

/* File: verification/roa_nv_model.sv */
// nonvolatile store model for the remote output assignment block
`timescale 1ns/100ps
`default_nettype none

module roa_nv_model (
  // clock
  input wire logic clk_sys,
  // store port
  input wire roa_pkg::roa_nv_save_type nv_save,
  output roa_pkg::roa_nv_load_type nv_load
);
  // ==========================================================================
  // store
  // never-saved contents are junk, so the block must not trust them
  roa_pkg::roa_nv_load_type mem_q = '{saved: 4'h0, value: 12'hb6d};

  assign nv_load = mem_q;
  always @(posedge clk_sys) begin
    if (nv_save.save === 1'b1) begin
      mem_q <= '{saved: 4'hf, value: nv_save.value};
    end
  end
endmodule // roa_nv_model

`default_nettype wire

/* File: verification/tb_top.sv */
// testbench for the remote output assignment block
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  // ==========================================================================
  // signals
  logic clk_sys;
  logic nrst;
  roa_pkg::roa_bus_req_type bus;
  logic [31:0] rdata;
  roa_pkg::roa_status_type status;
  roa_pkg::roa_nv_load_type nv_load;
  roa_pkg::roa_nv_save_type nv_save;
  logic [roa_pkg::NUM_OUT-1:0] remote_out;
  int err_count;
  int samples_checked;

  roa_remote_out uut (.clk_sys(clk_sys), .nrst(nrst), .bus(bus), .rdata(rdata), .status(status),
    .nv_load(nv_load), .nv_save(nv_save), .remote_out(remote_out));
  roa_nv_model store (.clk_sys(clk_sys), .nv_save(nv_save), .nv_load(nv_load));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // ==========================================================================
  // helpers
  function automatic logic [7:0] stg(input int s);
    return roa_pkg::ADDR_STAGE_BASE + 8'(4 * s);
  endfunction
  function automatic logic [7:0] eff(input int s);
    return roa_pkg::ADDR_EFF_BASE + 8'(4 * s);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    bus.wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic out_chk(input logic [3:0] st, input logic [31:0] exp);
    @(posedge clk_sys);
    status <= st;
    tick(2);
    chk({26'h000_0000, remote_out}, exp);
  endtask
  task automatic do_reset;
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    tick(3);
  endtask

  // ==========================================================================
  // scenarios
  task automatic sc_fresh;
    for (int s = 0; s < roa_pkg::NUM_SIG; s++) begin
      rchk(eff(s), 32'h0000_0000);
      rchk(stg(s), 32'h0000_0000);
    end
    rchk(roa_pkg::ADDR_GP_OUT, 32'h0000_0000);
    out_chk(4'hf, 32'h0000_0000);
  endtask
  task automatic sc_stage;
    wr(stg(0), 32'h0000_0001);
    wr(stg(1), 32'h0000_0002);
    wr(stg(2), 32'h0000_0002);
    wr(stg(3), 32'h0000_0006);
    wr(stg(3), 32'h0000_0007);
    wr(stg(3), 32'h0001_0000);
    rchk(stg(3), 32'h0000_0006);
    wr(stg(3), 32'h0000_0000);
    rchk(stg(3), 32'h0000_0000);
    rchk(eff(1), 32'h0000_0000);
    out_chk(4'hf, 32'h0000_0000);
  endtask
  task automatic sc_save;
    wr(roa_pkg::ADDR_CTRL, 32'h0000_0001);
    #1;
    chk(32'(nv_save.save), 32'h0000_0001);
    tick(1);
    chk({20'h0_0000, nv_save.value}, 32'h0000_0091);
    chk(32'(nv_save.save), 32'h0000_0000);
    do_reset;
    rchk(eff(0), 32'h0000_0001);
    rchk(eff(1), 32'h0000_0002);
    rchk(eff(2), 32'h0000_0002);
    rchk(eff(3), 32'h0000_0000);
  endtask
  task automatic sc_route;
    wr(roa_pkg::ADDR_GP_OUT, 32'h0000_003f);
    out_chk(4'h0, 32'h0000_003c);
    out_chk(4'h1, 32'h0000_003d);
    out_chk(4'h2, 32'h0000_003e);
    out_chk(4'h4, 32'h0000_003e);
    out_chk(4'h8, 32'h0000_003c);
    wr(roa_pkg::ADDR_SINGLE, 32'h0000_0011);
    wr(roa_pkg::ADDR_SINGLE, 32'h0000_0006);
    out_chk(4'h0, 32'h0000_001c);
    wr(roa_pkg::ADDR_SINGLE, 32'h0000_0017);
    rchk(roa_pkg::ADDR_OUT_LEVEL, 32'h0000_001c);
  endtask
  // unsaved staging must be lost across a reset
  task automatic sc_discard;
    wr(stg(0), 32'h0000_0005);
    wr(eff(0), 32'h0000_0003);
    rchk(eff(0), 32'h0000_0001);
    do_reset;
    rchk(stg(0), 32'h0000_0001);
    rchk(eff(0), 32'h0000_0001);
  endtask

  // ==========================================================================
  // run control
  task automatic final_report;
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    nrst = 1'b0;
    bus = '0;
    status = '0;
    err_count = 0;
    samples_checked = 0;
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    tick(3);
    sc_fresh;
    sc_stage;
    sc_save;
    sc_route;
    sc_discard;
    final_report;
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    $display("BAD t=%0t run did not finish", $time);
    final_report;
  end
endmodule // tb_top

`default_nettype wire
